// ==== rtl/ldf_pkg.sv ====
// Operation
// - on enable drive isolation switch, wait 500us, latch off if output sense low
// - floating mode pin: field 00 mixed, 01 direct pwm, 10 analog
// - driven mode pin: low mixed, middle direct pwm, high analog
// - mixed mode above transfer point: analog, amplitude follows input duty
// - mixed mode below transfer point: amplitude at transfer level, duty scaled up
// - transfer point selectable between 25% and 12.5%
// - mixed output dimming 200Hz or 23kHz, independent of input frequency
// - direct pwm: full amplitude, duty and frequency copied from input
// - analog: measure input duty by counter, amplitude is full scale times duty
// - analog duty below 10% raises minimum sink regulation voltage
// - output on-time below 7us regulates output at 93% of trip level
// - channel count field picks strings 1-4, 1-3, 1-2 or string 1
// - phase shift: each active channel lags the previous by 360/n
// - phase shift enabled by register bit or mid-level serial pins
// - jitter range bit selects 1/10 or 1/16 of central frequency
// - spread field selects 1/100, 1/150, 1/200 modulation, 11 disables
// - protection pulls fault flag low, sets fault bit, releases 750us after
// - over-voltage trip stops switching and marks off strings with low sink
// - every 500us marked strings get a 10us probe pulse to recover
// - sink above short threshold for 7.7ms marks that string off
// - all used strings short 480ms marks all off into standby, if enabled
// - compensation saturated 40ms pulls flag low, isolation off, latch off
// - transfer select bit 0 gives 25%, 1 gives 12.5%, reset 0
package ldf_pkg;

  localparam int NCH     = 4;
  localparam int CW      = 32;
  localparam int ADDR_W  = 8;
  localparam int CLK_MHZ = 250;
  localparam int CLK_HZ  = CLK_MHZ * 1000000;

  // times in their own units, then cycle counts
  localparam int T_START_US    = 500;
  localparam int T_RETRY_US    = 500;
  localparam int T_PROBE_US    = 10;
  localparam int T_FLAG_US     = 750;
  localparam int T_DEEP_US     = 7;
  localparam int T_SHORT_US    = 7700;
  localparam int T_ALLSHORT_MS = 480;
  localparam int T_COMP_MS     = 40;
  localparam int T_DIM_TO_MS   = 20;
  localparam int F_MIX_LO_HZ   = 200;
  localparam int F_MIX_HI_HZ   = 23000;

  localparam int START_CYC    = T_START_US * CLK_MHZ;
  localparam int RETRY_CYC    = T_RETRY_US * CLK_MHZ;
  localparam int PROBE_CYC    = T_PROBE_US * CLK_MHZ;
  localparam int FLAG_CYC     = T_FLAG_US * CLK_MHZ;
  localparam int DEEP_CYC     = T_DEEP_US * CLK_MHZ;
  localparam int SHORT_CYC    = T_SHORT_US * CLK_MHZ;
  localparam int ALLSHORT_CYC = T_ALLSHORT_MS * 1000 * CLK_MHZ;
  localparam int COMP_CYC     = T_COMP_MS * 1000 * CLK_MHZ;
  localparam int DIM_TO_CYC   = T_DIM_TO_MS * 1000 * CLK_MHZ;
  // 256 phase steps per output dimming period
  localparam int MIX_STEP_LO  = CLK_HZ / F_MIX_LO_HZ / 256;
  localparam int MIX_STEP_HI  = CLK_HZ / F_MIX_HI_HZ / 256;

  // duty scale: 8'hff is full scale
  localparam logic [7:0] DUTY_FULL  = 8'hff;
  localparam logic [7:0] TP_25      = 8'h40;
  localparam logic [7:0] TP_125     = 8'h20;
  localparam logic [7:0] DUTY_10PCT = 8'h1a;
  localparam logic [7:0] PH_Q       = 8'h40;
  localparam logic [7:0] PH_H       = 8'h80;
  localparam logic [7:0] PH_3Q      = 8'hc0;
  localparam logic [7:0] PH_T1      = 8'h55;
  localparam logic [7:0] PH_T2      = 8'hab;

  // register indices, byte address is index times four
  localparam logic [5:0] REG_FUNC  = 6'h00;
  localparam logic [5:0] REG_CHAN  = 6'h01;
  localparam logic [5:0] REG_FAULT = 6'h02;
  localparam logic [5:0] REG_ID    = 6'h03;
  localparam logic [5:0] REG_DUTY  = 6'h04;

  localparam logic [7:0] FUNC_RST  = 8'h02;
  localparam logic [7:0] CHAN_RST  = 8'h00;
  localparam int FUNC_MODE = 5;
  localparam int FUNC_TP   = 4;
  localparam int FUNC_FR   = 3;
  localparam int FUNC_SPR  = 1;
  localparam int FUNC_JIT  = 0;
  localparam int CHAN_PSE  = 7;
  localparam int CHAN_THR  = 5;
  localparam int FLT_SEN   = 7;
  localparam int FLT_DIS   = 6;
  localparam int FLT_LEDG  = 5;
  localparam int FLT_UVP   = 3;
  localparam int FLT_SHORT = 1;
  localparam int FLT_OPEN  = 0;

  localparam logic [1:0] MODE_MIXED  = 2'b00;
  localparam logic [1:0] MODE_PWM    = 2'b01;
  localparam logic [1:0] MODE_ANALOG = 2'b10;
  localparam logic [2:0] CH_3        = 3'b011;
  localparam logic [2:0] CH_2        = 3'b100;
  localparam logic [2:0] CH_1        = 3'b101;
  localparam logic [1:0] SPR_100     = 2'b00;
  localparam logic [1:0] SPR_150     = 2'b01;
  localparam logic [1:0] SPR_200     = 2'b10;
  localparam logic [7:0] DIV_100     = 8'h64;
  localparam logic [7:0] DIV_150     = 8'h96;
  localparam logic [7:0] DIV_200     = 8'hc8;
  localparam logic [4:0] JIT_10      = 5'h0a;
  localparam logic [4:0] JIT_16      = 5'h10;

  typedef enum logic [1:0] {PIN_LOW, PIN_MID, PIN_HIGH, PIN_OTHER} ldf_pin_lvl_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_RUN, ST_LATCH} ldf_fsm_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } ldf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ldf_apb_rsp_t;

  typedef struct packed {
    logic           enable;
    logic           brightness_pwm_input;
    logic           output_sense_low;
    logic           mode_pin_float;
    ldf_pin_lvl_t   mode_pin_level;
    logic           phase_pin_mid;
    logic           ovp_trip;
    logic           comp_sat;
    logic [NCH-1:0] sink_low;
    logic [NCH-1:0] sink_short;
  } ldf_sense_t;

  typedef struct packed {
    logic           isolation_switch_drive;
    logic           fault_flag_output;
    logic           stop_switching;
    logic [NCH-1:0] string_on;
    logic [7:0]     amplitude;
    logic           raise_min_sink;
    logic           regulate_ovp93;
    logic           spread_enable;
    logic [7:0]     spread_divisor;
    logic [4:0]     jitter_divisor;
    logic [1:0]     short_threshold_field;
  } ldf_drive_t;

endpackage : ldf_pkg

// ==== rtl/ldf_top.sv ====
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module ldf_top #(
  parameter int unsigned P_START_CYC    = ldf_pkg::START_CYC,
  parameter int unsigned P_RETRY_CYC    = ldf_pkg::RETRY_CYC,
  parameter int unsigned P_FLAG_CYC     = ldf_pkg::FLAG_CYC,
  parameter int unsigned P_SHORT_CYC    = ldf_pkg::SHORT_CYC,
  parameter int unsigned P_ALLSHORT_CYC = ldf_pkg::ALLSHORT_CYC,
  parameter int unsigned P_COMP_CYC     = ldf_pkg::COMP_CYC,
  parameter int unsigned P_DIM_TO_CYC   = ldf_pkg::DIM_TO_CYC,
  parameter int unsigned P_MIX_STEP_LO  = ldf_pkg::MIX_STEP_LO,
  parameter int unsigned P_MIX_STEP_HI  = ldf_pkg::MIX_STEP_HI,
  // arbitrary identity value
  parameter logic [7:0]  P_ID           = 8'h2a
) (
  // clock and reset
  input  logic                 core_clk,
  input  logic                 nrst,
  // register bus
  input  ldf_pkg::ldf_apb_req_t apb_req,
  output ldf_pkg::ldf_apb_rsp_t apb_rsp,
  // comparator and pin levels
  input  ldf_pkg::ldf_sense_t   sense,
  // driver controls
  output ldf_pkg::ldf_drive_t   drive
);
  import ldf_pkg::*;

  typedef struct packed {
    ldf_fsm_t                  fsm;
    logic [CW-1:0]             cnt;
    logic [7:0]                func;
    logic [7:0]                chan;
    logic                      all_short_enable;
    logic                      dis;
    logic [5:0]                flt;
    ldf_apb_rsp_t              rsp;
    logic                      dim_q;
    logic                      seen;
    logic [CW-1:0]             hi_cnt;
    logic [CW-1:0]             per_cnt;
    logic [CW-1:0]             hi_lat;
    logic [CW-1:0]             per_lat;
    logic [CW-1:0]             tdir;
    logic                      div_busy;
    logic [3:0]                div_i;
    logic [CW:0]               rem;
    logic [7:0]                quo;
    logic [7:0]                duty;
    logic [CW-1:0]             step;
    logic [7:0]                phase;
    logic [CW-1:0]             on_cnt;
    logic                      base0_q;
    logic [NCH-1:0]            marked;
    logic [NCH-1:0][CW-1:0]    short_cnt;
    logic [CW-1:0]             all_cnt;
    logic                      standby;
    logic [CW-1:0]             comp_cnt;
    logic [CW-1:0]             probe_tmr;
    logic                      probe_on;
    logic [CW-1:0]             flag_cnt;
    ldf_drive_t                drv;
  } ldf_st_t;

  ldf_st_t s;
  ldf_st_t n;

  function automatic logic [7:0] ldf_frac(input logic [2:0] nc, input int k);
    logic [7:0] f;
    f = 8'h00;
    if (nc == 3'd4) begin
      f = (k == 1) ? PH_Q : (k == 2) ? PH_H : (k == 3) ? PH_3Q : 8'h00;
    end else if (nc == 3'd3) begin
      f = (k == 1) ? PH_T1 : (k == 2) ? PH_T2 : 8'h00;
    end else if (nc == 3'd2) begin
      f = (k == 1) ? PH_H : 8'h00;
    end
    return f;
  endfunction : ldf_frac

  // mode, channel set and phase enable from registers and pins
  logic [1:0]     mode;
  logic [NCH-1:0] used;
  logic [2:0]     nch;
  logic           ps_on;
  logic [7:0]     tp;
  logic           mix_full;
  logic [7:0]     dout;
  logic [NCH-1:0] base;
  logic [5:0]     idx;
  logic           hit;
  logic [7:0]     rd_val;

  always_comb begin
    if (sense.mode_pin_float) begin
      mode = (s.func[FUNC_MODE+:2] == MODE_PWM) ? MODE_PWM :
             (s.func[FUNC_MODE+:2] == MODE_ANALOG) ? MODE_ANALOG : MODE_MIXED;
    end else begin
      case (sense.mode_pin_level)
        PIN_MID:  mode = MODE_PWM;
        PIN_HIGH: mode = MODE_ANALOG;
        default:  mode = MODE_MIXED;
      endcase
    end
    case (s.chan[2:0])
      CH_3: begin used = 4'h7; nch = 3'd3; end
      CH_2: begin used = 4'h3; nch = 3'd2; end
      CH_1: begin used = 4'h1; nch = 3'd1; end
      default: begin used = 4'hf; nch = 3'd4; end
    endcase
    ps_on = s.chan[CHAN_PSE] | sense.phase_pin_mid;
    tp = s.func[FUNC_TP] ? TP_125 : TP_25;
    // scale duty below the transfer point
    mix_full = (s.duty >= tp);
    dout = s.func[FUNC_TP] ? {s.duty[4:0], 3'b000} : {s.duty[5:0], 2'b00};
  end

  for (genvar k = 0; k < NCH; k++) begin : g_ch
    logic [7:0]     frac;
    logic [7:0]     pm;
    logic [CW+7:0]  prod;
    logic [CW-1:0]  off;
    logic [CW-1:0]  rel;
    logic           dir_on;
    logic           mix_on;
    assign frac   = ps_on ? ldf_frac(nch, k) : 8'h00;
    assign pm     = s.phase - frac;
    assign prod   = (CW+8)'(s.per_lat) * (CW+8)'(frac);
    assign off    = prod[CW+7:8];
    assign rel    = (s.tdir >= off) ? s.tdir - off : s.tdir + s.per_lat - off;
    // channel without lag copies the input
    assign dir_on = (frac == 8'h00) ? sense.brightness_pwm_input : (rel < s.hi_lat);
    assign mix_on = mix_full | (pm < dout);
    assign base[k] = used[k] & ((mode == MODE_PWM) ? dir_on :
                                (mode == MODE_MIXED) ? mix_on : 1'b1);
  end

  // register read mux
  assign idx = apb_req.paddr[ADDR_W-1:2];
  assign hit = (apb_req.paddr[1:0] == 2'b00) && (idx <= REG_DUTY);
  always_comb begin
    case (idx)
      REG_FUNC:  rd_val = s.func;
      REG_CHAN:  rd_val = s.chan;
      REG_FAULT: rd_val = {s.all_short_enable, s.dis, s.flt};
      REG_ID:    rd_val = P_ID;
      REG_DUTY:  rd_val = s.duty;
      default:   rd_val = 8'h00;
    endcase
  end

  always_comb begin
    logic           en;
    logic           rise;
    logic           run;
    logic           fault_any;
    logic [NCH-1:0] drv_on;
    logic           all_short;
    en = 1'b0;
    rise = 1'b0;
    run = 1'b0;
    fault_any = 1'b0;
    drv_on = '0;
    all_short = 1'b0;
    n = s;

    // apb slave: answer prepared in setup, completes in the first access cycle
    n.rsp.pready  = 1'b0;
    n.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      n.rsp.pready  = 1'b1;
      n.rsp.prdata  = {24'h000000, rd_val};
      n.rsp.pslverr = !hit;
    end
    if (apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite && hit) begin
      case (idx)
        REG_FUNC: n.func = apb_req.pwdata[7:0];
        REG_CHAN: n.chan = apb_req.pwdata[7:0];
        REG_FAULT: begin
          n.all_short_enable = apb_req.pwdata[FLT_SEN];
          n.dis = apb_req.pwdata[FLT_DIS];
          n.flt = s.flt & ~apb_req.pwdata[5:0];
        end
        default: ;
      endcase
    end

    en = sense.enable & !s.dis;
    case (s.fsm)
      ST_IDLE: begin
        n.drv.isolation_switch_drive = 1'b0;
        if (en) begin
          n.fsm = ST_CHECK;
          n.cnt = '0;
          n.drv.isolation_switch_drive = 1'b1;
        end
      end
      ST_CHECK: begin
        n.cnt = s.cnt + 1'b1;
        if (!en) begin
          n.fsm = ST_IDLE;
        end else if (s.cnt == CW'(P_START_CYC - 1)) begin
          if (sense.output_sense_low) begin
            n.fsm = ST_LATCH;
            n.flt[FLT_UVP] = 1'b1;
          end else begin
            n.fsm = ST_RUN;
            n.marked = '0;
            n.standby = 1'b0;
          end
        end
      end
      ST_RUN: begin
        if (!en) begin
          n.fsm = ST_IDLE;
        end else if (s.comp_cnt == CW'(P_COMP_CYC - 1) && sense.comp_sat) begin
          n.fsm = ST_LATCH;
          n.flt[FLT_LEDG] = 1'b1;
        end
      end
      ST_LATCH: begin
        n.drv.isolation_switch_drive = 1'b0;
        if (!sense.enable) begin
          n.fsm = ST_IDLE;
        end
      end
      default: n.fsm = ST_IDLE;
    endcase
    run = (s.fsm == ST_RUN);
    n.comp_cnt = (run && sense.comp_sat) ? s.comp_cnt + 1'b1 : '0;

    // duty measurement, one update per complete input period
    n.dim_q = sense.brightness_pwm_input;
    rise = sense.brightness_pwm_input & !s.dim_q;
    n.tdir = rise ? '0 : s.tdir + 1'b1;
    if (rise) begin
      n.seen = 1'b1;
      n.hi_cnt = CW'(1);
      n.per_cnt = CW'(1);
      if (s.seen) begin
        n.hi_lat = s.hi_cnt;
        n.per_lat = s.per_cnt;
        n.div_busy = 1'b1;
        n.div_i = '0;
        n.rem = {1'b0, s.hi_cnt};
        n.quo = '0;
      end
    end else if (s.per_cnt == CW'(P_DIM_TO_CYC)) begin
      // input stuck: treat as constant duty, no division needed
      n.duty = sense.brightness_pwm_input ? DUTY_FULL : 8'h00;
      n.seen = 1'b0;
    end else begin
      n.per_cnt = s.per_cnt + 1'b1;
      n.hi_cnt = s.hi_cnt + CW'(sense.brightness_pwm_input);
    end
    // serial divider: eight restoring steps keep the area small
    if (s.div_busy) begin
      if (s.rem[CW-1:0] >= s.per_lat) begin
        n.duty = DUTY_FULL;
        n.div_busy = 1'b0;
      end else begin
        n.rem = {s.rem[CW-1:0], 1'b0};
        n.quo = {s.quo[6:0], 1'b0};
        if ({s.rem[CW-1:0], 1'b0} >= {1'b0, s.per_lat}) begin
          n.rem = {s.rem[CW-1:0], 1'b0} - {1'b0, s.per_lat};
          n.quo = {s.quo[6:0], 1'b1};
        end
        n.div_i = s.div_i + 1'b1;
        if (s.div_i == 4'h7) begin
          n.div_busy = 1'b0;
          n.duty = n.quo;
        end
      end
    end

    // internal dimming period, free of the input frequency
    if (s.step >= (s.func[FUNC_FR] ? CW'(P_MIX_STEP_HI - 1) : CW'(P_MIX_STEP_LO - 1))) begin
      n.step = '0;
      n.phase = s.phase + 1'b1;
    end else begin
      n.step = s.step + 1'b1;
    end

    case (mode)
      MODE_PWM:    n.drv.amplitude = DUTY_FULL;
      MODE_ANALOG: n.drv.amplitude = s.duty;
      default:     n.drv.amplitude = mix_full ? s.duty : tp;
    endcase
    n.drv.raise_min_sink = (mode == MODE_ANALOG) && (s.duty < DUTY_10PCT);

    // on-time of the output dimming pulse
    n.base0_q = base[0];
    if (base[0]) begin
      n.on_cnt = (s.on_cnt == CW'(DEEP_CYC)) ? s.on_cnt : s.on_cnt + 1'b1;
      if (s.on_cnt == CW'(DEEP_CYC)) begin
        n.drv.regulate_ovp93 = 1'b0;
      end
    end else begin
      n.on_cnt = '0;
      if (s.base0_q) begin
        n.drv.regulate_ovp93 = (s.on_cnt < CW'(DEEP_CYC));
      end
    end

    n.probe_tmr = (s.probe_tmr == CW'(P_RETRY_CYC - 1)) ? '0 : s.probe_tmr + 1'b1;
    n.probe_on = (s.probe_tmr < CW'(PROBE_CYC));
    if (run && s.probe_on && !n.probe_on) begin
      n.marked = s.marked & (sense.sink_low | sense.sink_short);
      if ((sense.sink_short & used) == '0) begin
        n.standby = 1'b0;
      end
    end

    // open strings marked on over-voltage trip
    if (run && sense.ovp_trip && (used & sense.sink_low & ~s.marked) != '0) begin
      n.marked = n.marked | (used & sense.sink_low);
      n.flt[FLT_OPEN] = 1'b1;
    end

    drv_on = used & ~s.marked & s.drv.string_on;
    for (int k = 0; k < NCH; k++) begin
      if (drv_on[k] && sense.sink_short[k]) begin
        n.short_cnt[k] = s.short_cnt[k] + 1'b1;
        if (s.short_cnt[k] == CW'(P_SHORT_CYC - 1)) begin
          n.marked[k] = 1'b1;
          n.flt[FLT_SHORT] = 1'b1;
          n.short_cnt[k] = '0;
        end
      end else if (drv_on[k] || s.marked[k] || !run) begin
        n.short_cnt[k] = '0;
      end
    end

    // all-short standby, gated by its enable bit
    all_short = s.all_short_enable && run && ((used & sense.sink_short) == used);
    n.all_cnt = all_short ? s.all_cnt + 1'b1 : '0;
    if (all_short && s.all_cnt == CW'(P_ALLSHORT_CYC - 1)) begin
      n.standby = 1'b1;
      n.marked = used;
      n.flt[FLT_SHORT] = 1'b1;
      n.all_cnt = '0;
    end

    for (int k = 0; k < NCH; k++) begin
      n.drv.string_on[k] = run && used[k] &&
                           (s.marked[k] ? s.probe_on : (!s.standby && base[k]));
    end
    // switching held off during a trip or outside run
    n.drv.stop_switching = !run || sense.ovp_trip || s.standby;

    fault_any = (s.fsm == ST_LATCH) || (s.marked != '0) || s.standby ||
                (run && sense.ovp_trip);
    if (fault_any) begin
      n.drv.fault_flag_output = 1'b0;
      n.flag_cnt = '0;
    end else if (!s.drv.fault_flag_output) begin
      n.flag_cnt = s.flag_cnt + 1'b1;
      if (s.flag_cnt == CW'(P_FLAG_CYC - 1)) begin
        n.drv.fault_flag_output = 1'b1;
      end
    end

    n.drv.spread_enable = (s.func[FUNC_SPR+:2] != 2'b11);
    case (s.func[FUNC_SPR+:2])
      SPR_100: n.drv.spread_divisor = DIV_100;
      SPR_150: n.drv.spread_divisor = DIV_150;
      SPR_200: n.drv.spread_divisor = DIV_200;
      default: n.drv.spread_divisor = 8'h00;
    endcase
    n.drv.jitter_divisor = s.func[FUNC_JIT] ? JIT_16 : JIT_10;
    n.drv.short_threshold_field = s.chan[CHAN_THR+:2];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.func <= FUNC_RST;
      s.chan <= CHAN_RST;
      s.drv.fault_flag_output <= 1'b1;
      s.drv.stop_switching <= 1'b1;
      s.drv.spread_enable <= 1'b1;
      s.drv.spread_divisor <= DIV_150;
      s.drv.jitter_divisor <= JIT_10;
    end else begin
      s <= n;
    end
  end

  assign apb_rsp = s.rsp;
  assign drive   = s.drv;

endmodule : ldf_top

// ==== tb/ldf_partner.sv ====
`timescale 1ns/1ps
module ldf_partner (
  // clock and reset
  input  logic       core_clk,
  input  logic       nrst,
  // pwm shape in cycles
  input  int         per,
  input  int         hi,
  // string array
  input  logic [3:0] short_m,
  input  logic [3:0] string_on,
  input  logic [3:0] open_m,
  output logic       pwm,
  output logic [3:0] sink_low,
  output logic [3:0] sink_short
);
  int cnt;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) cnt <= 0;
    else cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
  end
  assign pwm = cnt < hi;
  // an open string pulls its sink to ground whether driven or not
  assign sink_low = open_m;
  assign sink_short = string_on & short_m;
endmodule : ldf_partner

// ==== tb/ldf_properties.sv ====
`timescale 1ns/1ps
module ldf_chk (
  // clock and reset
  input logic                  core_clk,
  input logic                  nrst,
  // watched ports
  input ldf_pkg::ldf_apb_req_t apb_req,
  input ldf_pkg::ldf_apb_rsp_t apb_rsp,
  input ldf_pkg::ldf_sense_t   sense,
  input ldf_pkg::ldf_drive_t   drive
);
  import ldf_pkg::*;
  logic [7:0] func_r;
  logic [7:0] func_q;
  logic [7:0] chan_r;
  logic [7:0] chan_q;
  logic [7:0] sdiv;
  logic [3:0] used;
  logic       wr;
  assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  assign sdiv = func_r[2:1] == SPR_100 ? DIV_100 : func_r[2:1] == SPR_150 ? DIV_150 :
                func_r[2:1] == SPR_200 ? DIV_200 : 8'h00;
  assign used = (chan_r[2:0] < 3'h3 || chan_r[2:0] > 3'h5) ? 4'hf : 4'hf >> (chan_r[2:0] - 3'h2);
  // shadow registers plus one cycle of history, outputs lag a write by one edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      func_r <= FUNC_RST;
      func_q <= FUNC_RST;
      chan_r <= CHAN_RST;
      chan_q <= CHAN_RST;
    end else begin
      func_q <= func_r;
      chan_q <= chan_r;
      if (wr && apb_req.paddr == {REG_FUNC, 2'h0}) func_r <= apb_req.pwdata[7:0];
      if (wr && apb_req.paddr == {REG_CHAN, 2'h0}) chan_r <= apb_req.pwdata[7:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_xfer;
    apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable;
  endsequence
  property p_rdy;
    s_xfer |-> apb_rsp.pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access cycle");
  property p_rdy1;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
  property p_iso_on;
    $rose(sense.enable) |-> ##[1:2] drive.isolation_switch_drive;
  endproperty
  a_iso_on: assert property (p_iso_on) else $error("isolation not driven");
  property p_iso_off;
    !sense.enable |-> ##[1:2] !drive.isolation_switch_drive;
  endproperty
  a_iso_off: assert property (p_iso_off) else $error("isolation on while off");
  property p_flag;
    $fell(drive.isolation_switch_drive) && sense.enable |-> ##[0:1] !drive.fault_flag_output;
  endproperty
  a_flag: assert property (p_flag) else $error("latch without flag");
  property p_jit;
    func_r == func_q |-> drive.jitter_divisor == (func_r[FUNC_JIT] ? JIT_16 : JIT_10);
  endproperty
  a_jit: assert property (p_jit) else $error("jitter divisor wrong");
  property p_spr;
    func_r == func_q |-> drive.spread_divisor == sdiv &&
      drive.spread_enable == (func_r[2:1] != 2'h3);
  endproperty
  a_spr: assert property (p_spr) else $error("spread setting wrong");
  property p_chan;
    chan_r == chan_q |-> (drive.string_on & ~used) == 4'h0;
  endproperty
  a_chan: assert property (p_chan) else $error("unused string driven");
endmodule : ldf_chk
bind ldf_top ldf_chk ldf_chk_inst (.core_clk(core_clk), .nrst(nrst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .sense(sense), .drive(drive));

// ==== tb/ldf_tb_top.sv ====
`timescale 1ns/1ps
module ldf_tb_top;
  import ldf_pkg::*;
  localparam int RETRY = 20000;
  logic         core_clk = 0;
  logic         nrst = 0;
  logic         en = 0;
  logic         osl = 1;
  logic         cs = 0;
  logic         pwm;
  logic         e;
  logic [3:0]   sm = 0;
  logic [3:0]   op = 0;
  logic         fl = 1;
  logic         ph = 0;
  logic         ov = 0;
  ldf_pin_lvl_t lv = PIN_LOW;
  int           per = 100;
  logic [3:0]   sl;
  logic [3:0]   ss;
  logic [31:0]  q;
  int           hi = 50;
  int           cyc = 0;
  int           fail_count = 0;
  int           comparisons = 0;
  ldf_apb_req_t rq = '0;
  ldf_apb_rsp_t rs;
  ldf_sense_t   sn;
  ldf_drive_t   dr;
  logic [7:0]   tf[6] = '{8'h40, 8'h40, 8'h20, 8'h00, 8'h00, 8'h10};
  logic [7:0]   ta[6] = '{8'h80, 8'h0d, 8'hff, 8'h40, 8'h80, 8'h20};
  int           th[6] = '{50, 5, 30, 10, 50, 10};
  always #2 core_clk = ~core_clk;
  assign sn = '{en, pwm, osl, fl, lv, ph, ov, cs, sl, ss};
  ldf_top #(.P_START_CYC(50), .P_RETRY_CYC(RETRY), .P_FLAG_CYC(50), .P_SHORT_CYC(200),
    .P_ALLSHORT_CYC(400), .P_COMP_CYC(100), .P_DIM_TO_CYC(5000), .P_MIX_STEP_LO(2),
    .P_MIX_STEP_HI(1)) ldf_top_inst (.core_clk(core_clk), .nrst(nrst), .apb_req(rq),
    .apb_rsp(rs), .sense(sn), .drive(dr));
  ldf_partner ldf_partner_inst (.core_clk(core_clk), .nrst(nrst), .per(per), .hi(hi),
    .short_m(sm), .string_on(dr.string_on), .open_m(op), .pwm(pwm), .sink_low(sl),
    .sink_short(ss));
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    rq <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    rq.penable <= 1'b1;
    do @(posedge core_clk); while (rs.pready !== 1'b1);
    q = rs.prdata;
    e = rs.pslverr;
    rq <= '0;
  endtask : rw
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : cmp
  // amplitude is a counted ratio, so allow a few steps of rounding
  task automatic near(input string n, input logic [7:0] x, input logic [7:0] g);
    comparisons++;
    if ($isunknown(g) || g + 4 < x || g > x + 4) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : near
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt
  task automatic results;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    wt(4);
    nrst <= 1'b1;
    rw(0, 8'h00, 0);
    cmp("func", 32'h02, q);
    rw(0, 8'h04, 0);
    cmp("chan", 0, q);
    rw(1, 8'h14, 32'h5);
    cmp("unmapped", 1, e);
    en <= 1'b1;
    wt(60);
    cmp("iso", 0, dr.isolation_switch_drive);
    cmp("flag", 0, dr.fault_flag_output);
    rw(0, 8'h08, 0);
    cmp("uvp", 1, q[FLT_UVP]);
    en <= 1'b0;
    osl <= 1'b0;
    wt(3);
    en <= 1'b1;
    wt(60);
    cmp("iso", 1, dr.isolation_switch_drive);
    cmp("stop", 0, dr.stop_switching);
    for (int i = 0; i < 6; i++) begin
      rw(1, 8'h00, tf[i]);
      hi <= th[i];
      wt(400);
      near("amp", ta[i], dr.amplitude);
      if (tf[i] == 8'h40) cmp("raise", th[i] < 10, dr.raise_min_sink);
      if (tf[i] == 8'h20) cmp("deep", 1, dr.regulate_ovp93);
    end
    rw(1, 8'h00, 8'h40);
    hi <= 50;
    for (int c = 0; c < 6; c++) begin
      rw(1, 8'h04, c | ((c & 3) << 5));
      wt(20);
      cmp("strings", c < 3 ? 4'hf : 4'hf >> (c - 2), dr.string_on);
      cmp("sthr", c & 3, dr.short_threshold_field);
    end
    rw(1, 8'h04, 0);
    // driven mode pin overrides the analog register setting
    fl <= 1'b0;
    lv <= PIN_MID;
    ph <= 1'b1;
    @(posedge pwm);
    wt(25);
    cmp("phase", 1, dr.string_on[0] ^ dr.string_on[2]);
    cmp("amp", 8'hff, dr.amplitude);
    ph <= 1'b0;
    wt(3);
    cmp("phase", 0, dr.string_on[0] ^ dr.string_on[2]);
    lv <= PIN_HIGH;
    wt(3);
    near("amp", 8'h80, dr.amplitude);
    fl <= 1'b1;
    lv <= PIN_LOW;
    for (int s = 0; s < 4; s++) begin
      rw(1, 8'h00, 8'h40 | (s << 1) | (s & 1));
      wt(3);
      cmp("sdiv", s == 3 ? 0 : 100 + 50 * s, dr.spread_divisor);
      cmp("jit", s[0] ? 16 : 10, dr.jitter_divisor);
    end
    sm <= 4'h1;
    op <= 4'h2;
    ov <= 1'b1;
    wt(3);
    cmp("stop", 1, dr.stop_switching);
    ov <= 1'b0;
    wt(300);
    cmp("flag", 0, dr.fault_flag_output);
    rw(0, 8'h08, 0);
    cmp("short", 1, q[FLT_SHORT]);
    cmp("open", 1, q[FLT_OPEN]);
    sm <= 4'h0;
    op <= 4'h0;
    wt(RETRY + 3000);
    cmp("flag", 1, dr.fault_flag_output);
    cmp("strings", 4'hf, dr.string_on);
    cmp("deep", 0, dr.regulate_ovp93);
    rw(1, 8'h08, 32'h2);
    rw(0, 8'h08, 0);
    cmp("short", 0, q[FLT_SHORT]);
    cs <= 1'b1;
    wt(130);
    cmp("iso", 0, dr.isolation_switch_drive);
    cmp("flag", 0, dr.fault_flag_output);
    results();
  end
endmodule : ldf_tb_top
